// ==== core/dio_pkg.sv ====
// constants for the digital i/o process image block
// assumes one clock domain and byte-grouped images from the controller
package dio_pkg;
  localparam int BYTE_W = 8;
  localparam int IMG_BYTES = 16;
  localparam int OFS_W = 4;
  localparam int IN_POINTS = 16;
  localparam int DUAL_CH = 2;
  localparam int QUAD_CH = 4;
  // digital output bytes, counted from the end of the analog data
  localparam logic [OFS_W-1:0] DOB_SINGLE = 4'h0;
  localparam logic [OFS_W-1:0] DOB_DUAL = 4'h1;
  localparam logic [OFS_W-1:0] DOB_DUAL_DIAG = 4'h2;
  localparam logic [OFS_W-1:0] DOB_DUAL_CODE = 4'h3;
  localparam logic [OFS_W-1:0] DOB_QUAD = 4'h4;
  // bit positions inside an image byte
  localparam int BIT_CH1 = 0;
  localparam int BIT_CH2 = 1;
  localparam int BIT_QUAD_LO = 0;
  localparam int BIT_QUAD_HI = 3;
  localparam int BIT_MANUAL = 0;
  localparam int CODE_W = 2;
  // fault code encodings
  localparam logic [CODE_W-1:0] FC_NORMAL = 2'h0;
  localparam logic [CODE_W-1:0] FC_OPEN_OR_POS = 2'h1;
  localparam logic [CODE_W-1:0] FC_GND_OR_OVL = 2'h2;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  // pin bundle layout for the synchroniser
  localparam int SYNC_W = 31;
  localparam int SP_POINTS = 0;
  localparam int SP_MANUAL = 16;
  localparam int SP_OVL = 17;
  localparam int SP_SHORT = 19;
  localparam int SP_BROKEN = 21;
  localparam int SP_NOLOAD = 23;
  localparam int SP_SHPOS = 25;
  localparam int SP_SHGND = 27;
  localparam int SP_OVL2 = 29;
endpackage

// ==== core/dio_sync.sv ====
// two-flop synchroniser for a bundle of field pins
// assumes pins are asynchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module dio_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] stage1;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          stage1[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end else if (clk_en_i) begin
          stage1[g] <= pin_i[g];
          sync_o[g] <= stage1[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== core/dio_image.sv ====
// digital i/o process image: maps field channels to image bytes
// assumes exchange_i is a one-cycle strobe from same-clock fieldbus logic
`timescale 1ns/1ps
`default_nettype none
module dio_image
  import dio_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic exchange_i,
  input wire logic [dio_pkg::OFS_W-1:0] analog_bytes_i,
  input wire logic [dio_pkg::IMG_BYTES*dio_pkg::BYTE_W-1:0] out_image_i,
  input wire logic [dio_pkg::IN_POINTS-1:0] input_point_i,
  input wire logic manual_mode_i,
  input wire logic [dio_pkg::DUAL_CH-1:0] overload_i,
  input wire logic [dio_pkg::DUAL_CH-1:0] short_circuit_i,
  input wire logic [dio_pkg::DUAL_CH-1:0] broken_wire_i,
  input wire logic [dio_pkg::DUAL_CH-1:0] no_load_i,
  input wire logic [dio_pkg::DUAL_CH-1:0] short_pos_i,
  input wire logic [dio_pkg::DUAL_CH-1:0] short_gnd_i,
  input wire logic [dio_pkg::DUAL_CH-1:0] code_overload_i,
  output logic [15:0] in_points_word_o,
  output logic [dio_pkg::BYTE_W-1:0] in_manual_byte_o,
  output logic [dio_pkg::BYTE_W-1:0] in_diag_byte_o,
  output logic [dio_pkg::BYTE_W-1:0] in_code_byte_o,
  output logic single_out_o,
  output logic [dio_pkg::DUAL_CH-1:0] dual_out_o,
  output logic [dio_pkg::DUAL_CH-1:0] dual_diag_out_o,
  output logic [dio_pkg::DUAL_CH-1:0] dual_code_out_o,
  output logic [dio_pkg::QUAD_CH-1:0] quad_out_o,
  output logic exchange_done_o
);
  import dio_pkg::*;

  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] pins_s;
  logic [BYTE_W-1:0] byte_single;
  logic [BYTE_W-1:0] byte_dual;
  logic [BYTE_W-1:0] byte_dual_diag;
  logic [BYTE_W-1:0] byte_dual_code;
  logic [BYTE_W-1:0] byte_quad;
  logic [BYTE_W-1:0] next_diag_byte;
  logic [BYTE_W-1:0] next_code_byte;
  logic [BYTE_W-1:0] next_manual_byte;
  logic [IN_POINTS-1:0] next_points_word;
  logic manual_s;
  // synchronised fault pins, one bit per channel
  logic [DUAL_CH-1:0] flt_overload;
  logic [DUAL_CH-1:0] flt_short;
  logic [DUAL_CH-1:0] flt_broken;
  logic [DUAL_CH-1:0] flt_no_load;
  logic [DUAL_CH-1:0] flt_short_pos;
  logic [DUAL_CH-1:0] flt_short_gnd;
  logic [DUAL_CH-1:0] flt_code_ovl;
  logic take;

  // pin bundle laid out at the named positions
  assign pins[SP_POINTS +: IN_POINTS] = input_point_i;
  assign pins[SP_MANUAL] = manual_mode_i;
  assign pins[SP_OVL +: DUAL_CH] = overload_i;
  assign pins[SP_SHORT +: DUAL_CH] = short_circuit_i;
  assign pins[SP_BROKEN +: DUAL_CH] = broken_wire_i;
  assign pins[SP_NOLOAD +: DUAL_CH] = no_load_i;
  assign pins[SP_SHPOS +: DUAL_CH] = short_pos_i;
  assign pins[SP_SHGND +: DUAL_CH] = short_gnd_i;
  assign pins[SP_OVL2 +: DUAL_CH] = code_overload_i;

  dio_sync #(
    .W(SYNC_W)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .pin_i(pins),
    .sync_o(pins_s)
  );

  assign take = clk_en_i & exchange_i;

  // unpack the synchronised bundle into named lanes
  assign next_points_word = pins_s[SP_POINTS +: IN_POINTS];
  assign manual_s = pins_s[SP_MANUAL];
  assign flt_overload = pins_s[SP_OVL +: DUAL_CH];
  assign flt_short = pins_s[SP_SHORT +: DUAL_CH];
  assign flt_broken = pins_s[SP_BROKEN +: DUAL_CH];
  assign flt_no_load = pins_s[SP_NOLOAD +: DUAL_CH];
  assign flt_short_pos = pins_s[SP_SHPOS +: DUAL_CH];
  assign flt_short_gnd = pins_s[SP_SHGND +: DUAL_CH];
  assign flt_code_ovl = pins_s[SP_OVL2 +: DUAL_CH];

  // pick one digital byte placed after the analog bytes; beyond the image reads zero
  function automatic logic [BYTE_W-1:0] pick_byte(
    input logic [IMG_BYTES*BYTE_W-1:0] img,
    input logic [OFS_W-1:0] base,
    input logic [OFS_W-1:0] idx
  );
    logic [OFS_W:0] pos;
    pos = {1'b0, base} + {1'b0, idx};
    if (pos < (OFS_W+1)'(IMG_BYTES)) begin
      pick_byte = img[pos[OFS_W-1:0]*BYTE_W +: BYTE_W];
    end else begin
      pick_byte = BYTE_ZERO;
    end
  endfunction

  always_comb begin
    byte_single = pick_byte(out_image_i, analog_bytes_i, DOB_SINGLE);
    byte_dual = pick_byte(out_image_i, analog_bytes_i, DOB_DUAL);
    byte_dual_diag = pick_byte(out_image_i, analog_bytes_i, DOB_DUAL_DIAG);
    byte_dual_code = pick_byte(out_image_i, analog_bytes_i, DOB_DUAL_CODE);
    byte_quad = pick_byte(out_image_i, analog_bytes_i, DOB_QUAD);
  end

  // diagnostic flag per channel: any of the three faults sets it
  genvar c;
  generate
    for (c = 0; c < DUAL_CH; c++) begin : g_diag
      logic lane_flag;

      assign lane_flag = flt_overload[c] | flt_short[c] | flt_broken[c];
      assign next_diag_byte[c] = lane_flag;
    end
  endgenerate

  // fault code per channel; ground short or overload outranks an open load
  genvar f;
  generate
    for (f = 0; f < DUAL_CH; f++) begin : g_code
      logic [CODE_W-1:0] lane_code;

      always_comb begin
        if (flt_short_gnd[f] | flt_code_ovl[f]) begin
          lane_code = FC_GND_OR_OVL;
        end else if (flt_no_load[f] | flt_short_pos[f]) begin
          lane_code = FC_OPEN_OR_POS;
        end else begin
          lane_code = FC_NORMAL;
        end
      end

      assign next_code_byte[f*CODE_W +: CODE_W] = lane_code;
    end
  endgenerate

  // pad bits of every input byte stay clear
  assign next_diag_byte[BYTE_W-1:DUAL_CH] = '0;
  assign next_code_byte[BYTE_W-1:DUAL_CH*CODE_W] = '0;
  assign next_manual_byte = {{(BYTE_W-1){1'b0}}, manual_s};

  // input word, one flop per point, all taken at the same exchange
  genvar p;
  generate
    for (p = 0; p < IN_POINTS; p++) begin : g_point
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          in_points_word_o[p] <= 1'b0;
        end else if (take) begin
          in_points_word_o[p] <= next_points_word[p];
        end
      end
    end
  endgenerate

  // manual operation status byte
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_manual_byte_o <= BYTE_ZERO;
    end else if (take) begin
      in_manual_byte_o <= next_manual_byte;
    end
  end

  // one diagnostic flag per channel
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_diag_byte_o <= BYTE_ZERO;
    end else if (take) begin
      in_diag_byte_o <= next_diag_byte;
    end
  end

  // two-bit fault code per channel, channel 1 in the low pair
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_code_byte_o <= BYTE_ZERO;
    end else if (take) begin
      in_code_byte_o <= next_code_byte;
    end
  end

  // single output: bit 0 drives, bit 1 is never read
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      single_out_o <= 1'b0;
    end else if (take) begin
      single_out_o <= byte_single[BIT_CH1];
    end
  end

  // two-channel output, one control bit per lane
  genvar d;
  generate
    for (d = 0; d < DUAL_CH; d++) begin : g_dual
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          dual_out_o[d] <= 1'b0;
        end else if (take) begin
          dual_out_o[d] <= byte_dual[BIT_CH1+d];
        end
      end
    end
  endgenerate

  // two-channel output with diagnostic flags
  genvar e;
  generate
    for (e = 0; e < DUAL_CH; e++) begin : g_dual_diag
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          dual_diag_out_o[e] <= 1'b0;
        end else if (take) begin
          dual_diag_out_o[e] <= byte_dual_diag[BIT_CH1+e];
        end
      end
    end
  endgenerate

  // two-channel output with fault codes; control bits 2 and 3 never read
  genvar h;
  generate
    for (h = 0; h < DUAL_CH; h++) begin : g_dual_code
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          dual_code_out_o[h] <= 1'b0;
        end else if (take) begin
          dual_code_out_o[h] <= byte_dual_code[BIT_CH1+h];
        end
      end
    end
  endgenerate

  // four-channel output, bits 0 to 3 in channel order
  genvar q;
  generate
    for (q = 0; q < QUAD_CH; q++) begin : g_quad
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          quad_out_o[q] <= 1'b0;
        end else if (take) begin
          quad_out_o[q] <= byte_quad[BIT_QUAD_LO+q];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      exchange_done_o <= 1'b0;
    end else if (clk_en_i) begin
      exchange_done_o <= exchange_i;
    end
  end
endmodule
`default_nettype wire

// ==== sim/dio_image_sva.sv ====
// port assertions for the process image block
// assumes it is bound onto dio_image, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dio_image_sva
  import dio_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic exchange_i,
  input wire logic [dio_pkg::OFS_W-1:0] analog_bytes_i,
  input wire logic [dio_pkg::IMG_BYTES*dio_pkg::BYTE_W-1:0] out_image_i,
  input wire logic [dio_pkg::BYTE_W-1:0] in_manual_byte_o,
  input wire logic [dio_pkg::BYTE_W-1:0] in_code_byte_o,
  input wire logic single_out_o,
  input wire logic [dio_pkg::DUAL_CH-1:0] dual_out_o,
  input wire logic [dio_pkg::QUAD_CH-1:0] quad_out_o,
  input wire logic exchange_done_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  function automatic logic [7:0] by(input logic [127:0] img, input logic [3:0] a, input int k);
    return (int'(a) + k < IMG_BYTES) ? img[(int'(a) + k)*8 +: 8] : BYTE_ZERO;
  endfunction
  wire logic take = exchange_i && clk_en_i;
  wire logic [7:0] bs = by(out_image_i, analog_bytes_i, 0);
  wire logic [7:0] bd = by(out_image_i, analog_bytes_i, 1);
  wire logic [7:0] bq = by(out_image_i, analog_bytes_i, 4);
  property p_done; take |=> exchange_done_o; endproperty
  a_done: assert property (p_done) else $error("done pulse missing");
  property p_single; take |=> single_out_o == $past(bs[0]); endproperty
  a_single: assert property (p_single) else $error("single drive wrong");
  property p_dual; take |=> dual_out_o == $past(bd[1:0]); endproperty
  a_dual: assert property (p_dual) else $error("dual drive wrong");
  property p_quad; take |=> quad_out_o == $past(bq[3:0]); endproperty
  a_quad: assert property (p_quad) else $error("quad drive wrong");
  property p_hold; !take |=> $stable({single_out_o, dual_out_o, quad_out_o}); endproperty
  a_hold: assert property (p_hold) else $error("drive moved between exchanges");
  property p_man_pad; in_manual_byte_o[7:1] == 7'h00; endproperty
  a_man_pad: assert property (p_man_pad) else $error("manual byte pad set");
  property p_code_pad; in_code_byte_o[7:4] == 4'h0; endproperty
  a_code_pad: assert property (p_code_pad) else $error("code byte pad set");
  property p_code_enc; in_code_byte_o[1:0] != 2'h3 && in_code_byte_o[3:2] != 2'h3; endproperty
  a_code_enc: assert property (p_code_enc) else $error("fault code 11 seen");
endmodule
bind dio_image dio_image_sva chk_u (.ref_clk_i, .reset_i, .clk_en_i, .exchange_i,
  .analog_bytes_i, .out_image_i, .in_manual_byte_o, .in_code_byte_o, .single_out_o,
  .dual_out_o, .quad_out_o, .exchange_done_o);
`default_nettype wire

// ==== sim/dio_ctrl_model.sv ====
// controller model: lays digital bytes after the analog bytes
// assumes filler stands for analog data and unused bits
`timescale 1ns/1ps
`default_nettype none
module dio_ctrl_model
  import dio_pkg::*;
(
  input wire logic [dio_pkg::OFS_W-1:0] analog_bytes_i,
  input wire logic [dio_pkg::IMG_BYTES*dio_pkg::BYTE_W-1:0] fill_i,
  input wire logic [5*dio_pkg::BYTE_W-1:0] dig_i,
  output logic [dio_pkg::IMG_BYTES*dio_pkg::BYTE_W-1:0] out_image_o
);
  always_comb begin
    out_image_o = fill_i;
    for (int k = 0; k < 5; k++) begin
      if (int'(analog_bytes_i) + k < IMG_BYTES) begin
        out_image_o[(int'(analog_bytes_i) + k)*8 +: 8] = dig_i[k*8 +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_digital_io_process_image.sv ====
// self-checking bench for the process image block
// assumes dio_image, the controller model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_digital_io_process_image;
  import dio_pkg::*;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, exchange_i = 1'b0, man = 1'b0;
  logic [3:0] ana = 4'h0;
  logic [127:0] fill = '0, img;
  logic [39:0] dig = '0;
  logic [15:0] pts = '0, o_pts;
  logic [1:0] ovl = '0, sh = '0, br = '0, nl = '0, sp = '0, sg = '0, co = '0;
  logic [7:0] o_man, o_diag, o_code;
  logic o_s, o_done, seen;
  logic [1:0] o_d, o_dd, o_dc;
  logic [3:0] o_q;
  int err_count = 0, total_checks = 0, cyc = 0;
  dio_ctrl_model mdl_u (.analog_bytes_i(ana), .fill_i(fill), .dig_i(dig), .out_image_o(img));
  dio_image dut_u (.ref_clk_i, .reset_i, .clk_en_i, .exchange_i, .analog_bytes_i(ana),
    .out_image_i(img), .input_point_i(pts), .manual_mode_i(man), .overload_i(ovl),
    .short_circuit_i(sh), .broken_wire_i(br), .no_load_i(nl), .short_pos_i(sp),
    .short_gnd_i(sg), .code_overload_i(co), .in_points_word_o(o_pts),
    .in_manual_byte_o(o_man), .in_diag_byte_o(o_diag), .in_code_byte_o(o_code),
    .single_out_o(o_s), .dual_out_o(o_d), .dual_diag_out_o(o_dd), .dual_code_out_o(o_dc),
    .quad_out_o(o_q), .exchange_done_o(o_done));
  always #5 ref_clk_i = ~ref_clk_i;
  function automatic logic [7:0] dv(input int k);
    return (int'(ana) + k < 16) ? dig[k*8 +: 8] : 8'h00;
  endfunction
  function automatic logic [1:0] cd(input int c);
    return (sg[c] | co[c]) ? 2'h2 : ((nl[c] | sp[c]) ? 2'h1 : 2'h0);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      $display("Error %0t: run hung", $time);
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h05AB5389));
    repeat (2) @(negedge ref_clk_i);
    reset_i = 1'b0;
    for (int n = 0; n < 40; n++) begin
      @(negedge ref_clk_i);
      // first round ends the digital bytes on the last image byte, the next two push them past it
      ana = (n < 3) ? 4'(11 + 2*n) : 4'($urandom_range(11, 0));
      fill = {$urandom, $urandom, $urandom, $urandom};
      dig = {8'($urandom), $urandom};
      {ovl, sh, br, nl, sp, sg, co} = 14'($urandom);
      pts = 16'($urandom);
      man = 1'($urandom);
      if (n == 20) begin
        reset_i = 1'b1;
        @(negedge ref_clk_i);
        chk(o_pts, 16'h0);
        chk({o_man, o_diag}, 16'h0);
        chk({o_code, o_q, o_d, o_dd}, 16'h0);
        chk({12'h0, o_s, o_dc, o_done}, 16'h0);
        reset_i = 1'b0;
      end
      repeat (2) @(negedge ref_clk_i);
      if (n % 5 == 4) begin
        clk_en_i = 1'b0;
        exchange_i = 1'b1;
        @(negedge ref_clk_i);
        exchange_i = 1'b0;
        clk_en_i = 1'b1;
        repeat (2) @(negedge ref_clk_i) chk(16'(o_done), 16'h0);
      end
      exchange_i = 1'b1;
      @(negedge ref_clk_i);
      exchange_i = 1'b0;
      seen = o_done;
      chk(o_pts, pts);
      chk({8'h0, o_man}, {15'h0, man});
      chk({8'h0, o_diag}, {14'h0, ovl | sh | br});
      chk({8'h0, o_code}, {12'h0, cd(1), cd(0)});
      chk(16'(o_s), 16'(dv(0) & 8'h01));
      chk(16'(o_d), 16'(dv(1) & 8'h03));
      chk(16'(o_dd), 16'(dv(2) & 8'h03));
      if ((ovl | sh | br) != 2'h0) begin
        chk(16'(o_dd), 16'(dv(2) & 8'h03));
      end
      chk(16'(o_dc), 16'(dv(3) & 8'h03));
      chk(16'(o_q), 16'(dv(4) & 8'h0F));
      @(negedge ref_clk_i);
      chk(16'({seen, o_done}), 16'h2);
    end
    end_sim();
  end
endmodule
`default_nettype wire
